// ==== include/usbsc_consts.vh ====
// constants for the usb status/control register block
`ifndef USBSC_CONSTS_VH
`define USBSC_CONSTS_VH
// register byte offsets (word aligned)
`define USBSC_OFF_ERR_EN      8'h00
`define USBSC_OFF_IRQ_EN      8'h04
`define USBSC_OFF_IRQ_STAT    8'h08
`define USBSC_OFF_STATUS      8'h0c
`define USBSC_OFF_CONTROL     8'h10
`define USBSC_OFF_ADDR        8'h14
`define USBSC_OFF_ERR_FLAG    8'h18
// field positions
`define USBSC_PID_ERR_BIT     0
`define USBSC_ERR_GATE_BIT    1
`define USBSC_TRN_DONE_BIT    3
`define USBSC_CON_J           7
`define USBSC_CON_SE0         6
`define USBSC_CON_HALT        5
`define USBSC_CON_RST         4
`define USBSC_CON_HOST        3
`define USBSC_CON_RESUME      2
`define USBSC_CON_PPCLR       1
`define USBSC_CON_ON          0
// timing
`define USBSC_CLK_HZ          20000000
`define USBSC_FRAME_US        1000
`define USBSC_FRAME_CYC       20000
`define USBSC_LS_EOP_CYC      40
// fifo depth
`define USBSC_FIFO_DEPTH      4
`endif

// ==== tb/usbsc_assertions.sv ====
// assertions for the usb status/control register block
`timescale 1ns/1ps
`default_nettype none
`include "usbsc_consts.vh"
module usbsc_checker #(
  parameter FRAME_CYC = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic [31:0] rdata,
  input wire logic        trn_done,
  input wire logic        trn_ready,
  input wire logic        setup_rx,
  input wire logic        sof_pulse,
  input wire logic        bus_reset_out,
  input wire logic        pingpong_clear,
  input wire logic        module_enable,
  input wire logic        packet_halt_out,
  input wire logic        low_speed_next,
  input wire logic [6:0]  function_addr
);
  logic [2:0] cnt;
  wire pop = wr && addr == `USBSC_OFF_IRQ_STAT && wdata[3] && cnt != 0;
  wire ctl = wr && addr == `USBSC_OFF_CONTROL;
  // shadow fill level; a pop in the full cycle frees a slot at once
  always @(posedge clk or posedge rst)
    if (rst)
      cnt <= 3'h0;
    else
      cnt <= cnt + 3'(trn_done && trn_ready) - 3'(pop);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_upper_zero: assert property (rdata[31:8] == 0)
    else $error("upper read bits not zero");
  a_addr_write: assert property (wr && addr == `USBSC_OFF_ADDR
    |=> {low_speed_next, function_addr} == $past(wdata[7:0]))
    else $error("address register not taken");
  a_reset_drive: assert property (ctl |=> bus_reset_out == $past(wdata[4]))
    else $error("bus reset drive wrong");
  a_pp_clear: assert property (ctl |=> pingpong_clear == $past(wdata[1]))
    else $error("pointer clear wrong");
  a_setup_halt: assert property (setup_rx && module_enable && !ctl
    |=> packet_halt_out)
    else $error("setup did not halt packets");
  a_frame_mode: assert property (sof_pulse |-> !module_enable)
    else $error("frame start outside host mode");
  a_frame_gap: assert property (sof_pulse |=> !sof_pulse [*8])
    else $error("frame starts too close");
  a_ready_full: assert property (trn_ready == !(cnt == 4 && !pop))
    else $error("ready does not follow fill");
  c_frame: cover property (sof_pulse);
  c_full: cover property (!trn_ready);
  c_halt: cover property (setup_rx && module_enable);
endmodule // usbsc_checker
bind usbsc_regs usbsc_checker #(.FRAME_CYC(FRAME_CYC)) i_usbsc_checker (
  .clk, .rst, .addr, .wdata, .wr, .rdata, .trn_done, .trn_ready,
  .setup_rx, .sof_pulse, .bus_reset_out, .pingpong_clear, .module_enable,
  .packet_halt_out, .low_speed_next, .function_addr);
`default_nettype wire

// ==== tb/usbsc_partner.sv ====
// usb far side: transaction source and live line levels
`timescale 1ns/1ps
`default_nettype none
module usbsc_partner (
  input  wire logic       clk,
  input  wire logic       trn_ready,
  output logic            trn_done,
  output logic [3:0]      trn_endpoint,
  output logic            trn_tx,
  output logic            trn_odd,
  output logic            j_line_pin,
  output logic            se0_pin
);
  initial {trn_done, trn_endpoint, trn_tx, trn_odd} = 7'h0f;
  initial {j_line_pin, se0_pin} = 2'h0;
  // hold one status until taken; fields scrambled when idle
  task send(input logic [5:0] s);
    {trn_endpoint, trn_tx, trn_odd} <= s;
    trn_done <= 1'b1;
    @(posedge clk);
    while (!trn_ready) @(posedge clk);
    trn_done <= 1'b0;
    {trn_endpoint, trn_tx, trn_odd} <= ~s;
    @(posedge clk);
  endtask
  task line(input logic j, input logic z);
    j_line_pin <= j;
    se0_pin <= z;
  endtask
endmodule // usbsc_partner
`default_nettype wire

// ==== tb/usbsc_regs_bench.sv ====
// self-checking bench for the usb status/control register block
`timescale 1ns/1ps
`default_nettype none
`include "usbsc_consts.vh"
module usbsc_regs_bench;
  localparam CT = 8'h10, ST = 8'h0c, IS = 8'h08, AD = 8'h14;
  logic clk, rst, wr, rd, setup_rx, pid_check_fail, token_active;
  logic [7:0] addr;
  logic [31:0] wdata, d;
  wire logic [31:0] rdata;
  wire logic trn_done, trn_tx, trn_odd, trn_ready, j_line_pin, se0_pin;
  wire logic module_irq_flag, sof_pulse, bus_reset_out, resume_out;
  wire logic host_logic_rst, pingpong_clear, module_enable, ls_eop_out;
  wire logic packet_halt_out, low_speed_next;
  wire logic [3:0] trn_endpoint;
  wire logic [6:0] function_addr;
  integer errors = 0, checks = 0, cyc = 0, sofs = 0, hrst = 0, i;
  integer eops = 0, e;
  logic [5:0] s;
  logic [5:0] q[$];
  usbsc_regs #(.FRAME_CYC(20)) i_usbsc_regs (.clk, .rst, .addr, .wdata,
    .wr, .rd, .rdata, .j_line_pin, .se0_pin, .trn_done, .trn_endpoint,
    .trn_tx, .trn_odd, .trn_ready, .setup_rx, .pid_check_fail,
    .token_active, .module_irq_flag, .sof_pulse, .bus_reset_out,
    .resume_out, .ls_eop_out, .host_logic_rst, .pingpong_clear,
    .module_enable, .packet_halt_out, .low_speed_next, .function_addr);
  usbsc_partner i_usbsc_partner (.clk, .trn_ready, .trn_done,
    .trn_endpoint, .trn_tx, .trn_odd, .j_line_pin, .se0_pin);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // cycle limit plus pulse tallies
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    sofs <= sofs + sof_pulse;
    hrst <= hrst + host_logic_rst;
    eops <= eops + ls_eop_out;
    if (cyc == 5000)
    begin
      errors++;
      results;
    end
  end
  task chk(input string n, input logic [31:0] v, input logic [31:0] e);
    checks++;
    if (v !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, v);
    end
  endtask
  task w(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // read data stands only in the cycle after the strobe
  task r(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, e);
    @(posedge clk);
  endtask
  task results;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    {rst, wr, rd, setup_rx, pid_check_fail, token_active} = 6'h20;
    addr = 8'h00;
    wdata = 32'h0;
    void'($urandom(26063));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    r(AD, 0);
    r(8'h1c, 0);
    r(ST, 0);
    d = $urandom;
    w(AD, d);
    r(AD, d & 32'hff);
    chk("addr", {low_speed_next, function_addr}, d[7:0]);
    // five completions against four slots: the last must wait
    fork
      for (int k = 0; k < 5; k++)
      begin
        s = $urandom;
        q.push_back(s);
        i_usbsc_partner.send(s);
      end
    join_none
    repeat (16) @(posedge clk);
    chk("ready", trn_ready, 0);
    for (i = 0; i < 5; i++)
    begin
      r(IS, 8);
      r(ST, {q[0], 2'h0});
      w(IS, 8);
      void'(q.pop_front());
      repeat (3) @(posedge clk);
    end
    r(IS, 0);
    i_usbsc_partner.line(1'b1, 1'b0);
    w(CT, 32'h17);
    repeat (4) @(posedge clk);
    r(CT, 32'h97);
    chk("ctl", {bus_reset_out, resume_out, pingpong_clear, module_enable},
      4'hf);
    i_usbsc_partner.line(1'b0, 1'b1);
    setup_rx <= 1'b1;
    @(posedge clk);
    setup_rx <= 1'b0;
    repeat (4) @(posedge clk);
    r(CT, 32'h77);
    chk("halt", packet_halt_out, 1);
    token_active <= 1'b1;
    w(CT, 32'h0d);
    repeat (4) @(posedge clk);
    r(CT, 32'h6d);
    chk("hrst", hrst, 1);
    w(CT, 32'h09);
    i = sofs;
    e = eops;
    repeat (100) @(posedge clk);
    chk("sof", sofs - i, 5);
    chk("eop", eops - e, `USBSC_LS_EOP_CYC);
    r(CT, 32'h69);
    token_active <= 1'b0;
    repeat (2) @(posedge clk);
    r(CT, 32'h49);
    w(CT, 0);
    w(8'h00, 1);
    pid_check_fail <= 1'b1;
    w(8'h04, 2);
    pid_check_fail <= 1'b0;
    @(negedge clk) chk("irq", module_irq_flag, 1);
    @(posedge clk) w(8'h00, 0);
    @(negedge clk) chk("irq", module_irq_flag, 0);
    chk("hrst", hrst, 2);
    results;
  end
endmodule // usbsc_regs_bench
`default_nettype wire

// ==== verilog/usbsc_regs.v ====
// usb status, control and address register block
`timescale 1ns/1ps
`default_nettype none
`include "usbsc_consts.vh"
// Operation
// R1: pid failure enabled only by bit zero
// R2: error reaches module flag only when gated
// R3: status 7:4 report last endpoint number
// R4: status bit3 one for transmit
// R5: status bit2 one for odd bank
// R6: unimplemented bits read zero
// R7: status shows fifo head while done
// R8: clearing done flag pops status fifo
// R9: control bit7 live j state
// R10: control bit6 live single ended zero
// R11: device halt bit set on setup
// R12: host bit5 shows token executing
// R13: software checks busy before token write
// R14: bit4 drives bus reset signalling
// R15: host enable toggle resets host logic
// R16: software times resume 10/25 ms
// R17: resume drive, host appends eop
// R18: bit1 forces pointers to even bank
// R19: device bit0 enables module
// R20: host bit0 sends frame start each ms
// R21: address bit7 selects low speed next
// R22: address bits 6:0 hold bus address
// R23: full fifo stalls transaction completion

// register map, byte offsets on the plain register port:
//   0x00 error enable, bit0 passes the pid failure on
//   0x04 module interrupt enable, bit1 gates all error sources
//   0x08 module interrupt status, bit3 transfer done, write one pops
//   0x0c transaction status, endpoint 7:4, direction 3, bank 2
//   0x10 bus control, line levels 7:6 read only, 5:0 writable
//   0x14 function address, bit7 low speed, 6:0 bus address
//   0x18 error flags, bit0 pid failure, write one clears
// every bit not listed reads zero, writes to it are dropped

// port groups:
//   register port: addr, wdata, wr, rd in; rdata out one cycle later
//   line levels: j_line_pin, se0_pin, asynchronous, synchronised here
//   transaction side: trn_done with its status fields, trn_ready back
//   engine events: setup_rx, pid_check_fail, token_active
//   control outputs: levels that follow the control register bits
//   host timing: sof_pulse per frame, ls_eop_out after resume ends

// limitations:
//   the fifo entries hold no reset; they are only read while the
//   done flag shows at least one entry, so stale words never leak
//   the frame length is a parameter in clock cycles, so a slower
//   clock needs a matching FRAME_CYC or frames drift from 1 ms
//   the line levels lag the pins by two to three cycles; software
//   polling them sees no difference at register speed
module usbsc_regs #(
  parameter FRAME_CYC = `USBSC_FRAME_CYC
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  input  wire        j_line_pin,
  input  wire        se0_pin,
  input  wire        trn_done,
  input  wire [3:0]  trn_endpoint,
  input  wire        trn_tx,
  input  wire        trn_odd,
  output wire        trn_ready,
  input  wire        setup_rx,
  input  wire        pid_check_fail,
  input  wire        token_active,
  output wire        module_irq_flag,
  output reg         sof_pulse,
  output wire        bus_reset_out,
  output wire        resume_out,
  output reg         ls_eop_out,
  output wire        host_logic_rst,
  output wire        pingpong_clear,
  output wire        module_enable,
  output wire        packet_halt_out,
  output wire        low_speed_next,
  output wire [6:0]  function_addr
);
  localparam DEPTH = `USBSC_FIFO_DEPTH;
  localparam integer FRAME_LAST = FRAME_CYC - 1;
  localparam integer EOP_LAST   = `USBSC_LS_EOP_CYC - 1;
  // counters compare against the last count, cut to counter width
  localparam [15:0] FRAME_MAX = FRAME_LAST[15:0];
  localparam [7:0]  EOP_MAX   = EOP_LAST[7:0];

  reg        pid_err_en_reg, err_gate_reg, pid_flag_reg, done_reg;
  reg [5:0]  fifo_mem [0:DEPTH-1];
  reg [1:0]  rptr_reg, wptr_reg;
  reg [2:0]  count_reg;
  reg        halt_reg, rst_drv_reg, host_reg, resume_reg, ppclr_reg, on_reg;
  reg [7:0]  addr_reg;
  reg        host_prev_reg;
  reg [15:0] frame_cnt_reg;
  reg [7:0]  eop_cnt_reg;

  function sel;
    input [7:0] a;
    input [7:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  wire wr_err_en = wr && sel(addr, `USBSC_OFF_ERR_EN);
  wire wr_irq_en = wr && sel(addr, `USBSC_OFF_IRQ_EN);
  wire wr_irq_st = wr && sel(addr, `USBSC_OFF_IRQ_STAT);
  wire wr_con    = wr && sel(addr, `USBSC_OFF_CONTROL);
  wire wr_addr   = wr && sel(addr, `USBSC_OFF_ADDR);
  wire wr_eflag  = wr && sel(addr, `USBSC_OFF_ERR_FLAG);
  // write one to clear the done flag advances the fifo
  wire pop  = wr_irq_st && wdata[`USBSC_TRN_DONE_BIT] && (count_reg != 3'h0); // R8
  wire full = (count_reg == DEPTH[2:0]);
  assign trn_ready = !full || pop; // R23
  wire push = trn_done && trn_ready;

  // two-flop synchronisers for the bus line levels; the first stage can
  // go metastable, so nothing but the second stage reads it
  wire [1:0] line_pin = {j_line_pin, se0_pin};
  wire [1:0] line_sync;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_line_sync
      reg s1_reg;
      reg s2_reg;
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= line_pin[gi];
          s2_reg <= s1_reg;
        end
      end
      assign line_sync[gi] = s2_reg;
    end
  endgenerate
  wire j_sync   = line_sync[1]; // R9
  wire se0_sync = line_sync[0]; // R10

  // status fifo; entry = endpoint, direction, bank
  always @(posedge clk)
  begin
    if (push)
      fifo_mem[wptr_reg] <= {trn_endpoint, trn_tx, trn_odd}; // R3 R4 R5
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rptr_reg  <= 2'h0;
      wptr_reg  <= 2'h0;
      count_reg <= 3'h0;
    end
    else
    begin
      if (push)
        wptr_reg <= wptr_reg + 2'h1;
      if (pop)
        rptr_reg <= rptr_reg + 2'h1; // R8
      if (push && !pop)
        count_reg <= count_reg + 3'h1;
      else if (pop && !push)
        count_reg <= count_reg - 3'h1;
    end
  end

  // done flag is simply "fifo not empty", so a push during a pop survives
  always @*
    done_reg = (count_reg != 3'h0); // R7

  // error flag and enables; set wins over write-one-clear
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pid_err_en_reg <= 1'b0;
      err_gate_reg   <= 1'b0;
      pid_flag_reg   <= 1'b0;
    end
    else
    begin
      if (wr_err_en)
        pid_err_en_reg <= wdata[`USBSC_PID_ERR_BIT];
      if (wr_irq_en)
        err_gate_reg <= wdata[`USBSC_ERR_GATE_BIT];
      if (pid_check_fail)
        pid_flag_reg <= 1'b1;
      else if (wr_eflag && wdata[`USBSC_PID_ERR_BIT])
        pid_flag_reg <= 1'b0;
    end
  end

  assign module_irq_flag = pid_flag_reg && pid_err_en_reg // R1
                           && err_gate_reg; // R2

  // control and address registers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      halt_reg    <= 1'b0;
      rst_drv_reg <= 1'b0;
      host_reg    <= 1'b0;
      resume_reg  <= 1'b0;
      ppclr_reg   <= 1'b0;
      on_reg      <= 1'b0;
      addr_reg    <= 8'h00;
    end
    else
    begin
      if (wr_con)
      begin
        rst_drv_reg <= wdata[`USBSC_CON_RST]; // R14
        host_reg    <= wdata[`USBSC_CON_HOST];
        resume_reg  <= wdata[`USBSC_CON_RESUME];
        ppclr_reg   <= wdata[`USBSC_CON_PPCLR];
        on_reg      <= wdata[`USBSC_CON_ON];
      end
      // setup reception sets halt over a software write
      if (!host_reg && setup_rx)
        halt_reg <= 1'b1; // R11
      else if (wr_con)
        halt_reg <= wdata[`USBSC_CON_HALT];
      if (wr_addr)
        addr_reg <= wdata[7:0]; // R21 R22
    end
  end

  assign bus_reset_out   = rst_drv_reg; // R14
  assign resume_out      = resume_reg; // R17
  assign pingpong_clear  = ppclr_reg; // R18
  assign module_enable   = !host_reg && on_reg; // R19
  assign packet_halt_out = !host_reg && halt_reg; // R11
  assign low_speed_next  = addr_reg[7]; // R21
  assign function_addr   = addr_reg[6:0]; // R22
  // one-cycle pulse on any change of host enable
  assign host_logic_rst  = host_reg ^ host_prev_reg; // R15

  // host mode frame timer; a toggle of host enable restarts it, so the
  // first frame after a mode change is always a full one
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      host_prev_reg <= 1'b0;
      frame_cnt_reg <= 16'h0000;
      sof_pulse     <= 1'b0;
    end
    else
    begin
      host_prev_reg <= host_reg;
      sof_pulse     <= 1'b0;
      if (host_logic_rst || !(host_reg && on_reg))
        frame_cnt_reg <= 16'h0000; // R15
      else if (frame_cnt_reg == FRAME_MAX)
      begin
        frame_cnt_reg <= 16'h0000;
        sof_pulse     <= 1'b1; // R20
      end
      else
        frame_cnt_reg <= frame_cnt_reg + 16'h0001;
    end
  end

  // end of resume in host mode, seen on the clearing write itself so
  // the eop follows with no extra cycle of plain resume
  wire resume_end = host_reg && wr_con && resume_reg
                    && !wdata[`USBSC_CON_RESUME];

  // low-speed eop stretch; a host toggle cuts it short
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      eop_cnt_reg <= 8'h00;
      ls_eop_out  <= 1'b0;
    end
    else
    begin
      if (host_logic_rst)
      begin
        ls_eop_out  <= 1'b0;
        eop_cnt_reg <= 8'h00;
      end
      else if (resume_end)
      begin
        ls_eop_out  <= 1'b1; // R17
        eop_cnt_reg <= 8'h00;
      end
      else if (ls_eop_out)
      begin
        if (eop_cnt_reg == EOP_MAX)
          ls_eop_out <= 1'b0;
        eop_cnt_reg <= eop_cnt_reg + 8'h01;
      end
    end
  end

  // read mux; the word is built here and registered below, so the
  // read data never glitches with the strobe
  wire [5:0] head = fifo_mem[rptr_reg];
  reg  [31:0] rdata_next;
  always @*
  begin
    rdata_next = 32'h00000000; // R6
    if (rd)
    begin
      case (addr)
        `USBSC_OFF_ERR_EN:   rdata_next[0] = pid_err_en_reg;
        `USBSC_OFF_IRQ_EN:   rdata_next[1] = err_gate_reg;
        `USBSC_OFF_IRQ_STAT: rdata_next[3] = done_reg;
        `USBSC_OFF_STATUS:
          if (done_reg)
            rdata_next[7:2] = head; // R7
        `USBSC_OFF_CONTROL:
          rdata_next[7:0] = {j_sync, se0_sync, // R9 R10
                             host_reg ? token_active : halt_reg, // R12
                             rst_drv_reg, host_reg, resume_reg,
                             ppclr_reg, on_reg};
        `USBSC_OFF_ADDR:     rdata_next[7:0] = addr_reg;
        `USBSC_OFF_ERR_FLAG: rdata_next[0] = pid_flag_reg;
        default:             rdata_next = 32'h00000000;
      endcase
    end
  end

  // registered read data, zero in every cycle without a read
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 32'h00000000;
    else
      rdata <= rdata_next;
  end
endmodule // usbsc_regs
`default_nettype wire
